// ### pkg/bsmi_defs.svh
`ifndef BSMI_DEFS_SVH
`define BSMI_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BSMI_CLK_HZ          20000000
`define BSMI_TICK_MS         5
`define BSMI_TICK_CYC        (`BSMI_TICK_MS * (`BSMI_CLK_HZ / 1000))
`define BSMI_TIMEOUT_MS      10
`define BSMI_TIMEOUT_CYC     (`BSMI_TIMEOUT_MS * (`BSMI_CLK_HZ / 1000))

// ----------------------------------------------------------------
// Sequence and lamp layout
// ----------------------------------------------------------------
`define BSMI_LAST_STEP       6'h27
`define BSMI_MODE_LSB        0
`define BSMI_SRC_LSB         2
`define BSMI_LAMPS_OFF       5'h00
`define BSMI_LAMP_SRC_HIGH   3'h4
`define BSMI_LAMP_SRC_MID    3'h2
`define BSMI_LAMP_SRC_LOW    3'h6
`define BSMI_LAMP_SRC_EXT    3'h5
`define BSMI_LAMP_SRC_SUB    3'h3
`define BSMI_LAMP_MODE_NORM  2'h3
`define BSMI_LAMP_MODE_HALT  2'h2
`define BSMI_LAMP_MODE_STOP  2'h0
`define BSMI_LAMP_MODE_SNZ   2'h1

`endif

// ### pkg/bsmi_pkg.sv
package bsmi_pkg;

    typedef enum logic [2:0] {
        BSMI_SRC_HIGH = 3'h0,
        BSMI_SRC_MID  = 3'h1,
        BSMI_SRC_LOW  = 3'h2,
        BSMI_SRC_EXT  = 3'h3,
        BSMI_SRC_SUB  = 3'h4
    } bsmi_src_t;

    typedef enum logic [1:0] {
        BSMI_MODE_NORMAL = 2'h0,
        BSMI_MODE_HALT   = 2'h1,
        BSMI_MODE_STOP   = 2'h2,
        BSMI_MODE_SNOOZE = 2'h3
    } bsmi_mode_t;

    typedef struct packed {
        bsmi_src_t  src;
        bsmi_mode_t mode;
    } bsmi_step_t;

    typedef enum logic [2:0] {
        BSMI_DEB_IDLE   = 3'h1,
        BSMI_DEB_FIRST  = 3'h2,
        BSMI_DEB_SECOND = 3'h4
    } bsmi_deb_t;

    typedef enum logic [3:0] {
        BSMI_SEQ_RUN    = 4'h1,
        BSMI_SEQ_SWITCH = 4'h2,
        BSMI_SEQ_PARK   = 4'h4,
        BSMI_SEQ_FAIL   = 4'h8
    } bsmi_seq_t;

endpackage

// ### hdl/bsmi_top.sv
// Summary of operation
// - Only a falling switch edge starts a candidate press.
// - After a candidate, the switch is sampled every 5 ms tick.
// - A press is valid only when two consecutive samples agree.
// - Each valid press advances exactly one step, starting at step one.
// - Lamps three to five show the clock source pattern.
// - Lamps one and two show the operating mode pattern.
// - Steps 1 to 19 follow the fixed source and mode list.
// - Steps 20 to 39 follow the fixed source and mode list.
// - A press after step 39 blanks all lamps and parks.
// - Parked state is left only by reset; presses are ignored.
// - A clock switch that times out blanks lamps and stops sequencing.
`include "bsmi_defs.svh"

module bsmi_top
    import bsmi_pkg::*;
#(
    parameter int unsigned TICK_CYC    = `BSMI_TICK_CYC,
    parameter int unsigned TIMEOUT_CYC = `BSMI_TIMEOUT_CYC
)(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       switch_i,
    input  wire logic       clk_ack_i,
    output logic            clk_req_o,
    output bsmi_src_t       clk_src_o,
    output bsmi_mode_t      op_mode_o,
    output logic [4:0]      lamp_o,
    output logic [5:0]      step_o,
    output logic            parked_o,
    output logic            fault_o
);

    localparam int TW = $clog2(TICK_CYC + 1);
    localparam int WW = $clog2(TIMEOUT_CYC + 1);

    if (TICK_CYC < 2 || TIMEOUT_CYC < 2)
    begin : g_chk
        $error("bsmi_top: TICK_CYC and TIMEOUT_CYC must be at least 2");
    end

    // ----------------------------------------------------------------
    // Step table and lamp encoding
    // ----------------------------------------------------------------
    function automatic bsmi_step_t step_cfg(input logic [5:0] idx);
        bsmi_step_t c;
        c.src  = BSMI_SRC_HIGH;
        c.mode = BSMI_MODE_NORMAL;
        unique case (idx)
            6'h02, 6'h03, 6'h04, 6'h07, 6'h1F:
                c.src = BSMI_SRC_SUB;
            6'h06, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h15, 6'h17:
                c.src = BSMI_SRC_EXT;
            6'h14, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h20, 6'h22:
                c.src = BSMI_SRC_MID;
            6'h16, 6'h21, 6'h24, 6'h25, 6'h26:
                c.src = BSMI_SRC_LOW;
            default:
                c.src = BSMI_SRC_HIGH;
        endcase
        unique case (idx)
            6'h03, 6'h09, 6'h0E, 6'h19, 6'h25: c.mode = BSMI_MODE_HALT;
            6'h0B, 6'h10, 6'h1B:               c.mode = BSMI_MODE_STOP;
            6'h12, 6'h1D:                      c.mode = BSMI_MODE_SNOOZE;
            default:                           c.mode = BSMI_MODE_NORMAL;
        endcase
        return c;
    endfunction

    function automatic logic [4:0] lamps(input bsmi_step_t c);
        logic [2:0] s;
        logic [1:0] m;
        s = `BSMI_LAMP_SRC_HIGH;
        m = `BSMI_LAMP_MODE_NORM;
        unique case (c.src)
            BSMI_SRC_HIGH: s = `BSMI_LAMP_SRC_HIGH;
            BSMI_SRC_MID:  s = `BSMI_LAMP_SRC_MID;
            BSMI_SRC_LOW:  s = `BSMI_LAMP_SRC_LOW;
            BSMI_SRC_EXT:  s = `BSMI_LAMP_SRC_EXT;
            BSMI_SRC_SUB:  s = `BSMI_LAMP_SRC_SUB;
            default:       s = `BSMI_LAMP_SRC_HIGH;
        endcase
        unique case (c.mode)
            BSMI_MODE_NORMAL: m = `BSMI_LAMP_MODE_NORM;
            BSMI_MODE_HALT:   m = `BSMI_LAMP_MODE_HALT;
            BSMI_MODE_STOP:   m = `BSMI_LAMP_MODE_STOP;
            BSMI_MODE_SNOOZE: m = `BSMI_LAMP_MODE_SNZ;
        endcase
        return {s, m};
    endfunction

    // ----------------------------------------------------------------
    // Switch debounce
    // ----------------------------------------------------------------
    bsmi_deb_t       deb_q, deb_d;
    logic [TW-1:0]   tick_q, tick_d;
    logic            swp_q, swp_d;
    logic            smp_q, smp_d;
    logic            press_q, press_d;
    bsmi_seq_t       seq_q, seq_d;
    logic            fall;
    logic            tick_end;

    assign fall     = swp_q & ~switch_i;
    assign tick_end = (tick_q == TW'(TICK_CYC - 1));

    always_comb
    begin
        deb_d   = deb_q;
        tick_d  = tick_q;
        smp_d   = smp_q;
        press_d = 1'b0;
        swp_d   = switch_i;
        unique case (deb_q)
            BSMI_DEB_IDLE:
            begin
                if (fall && seq_q == BSMI_SEQ_RUN)
                begin
                    deb_d  = BSMI_DEB_FIRST;
                    tick_d = '0;
                end
            end
            BSMI_DEB_FIRST:
            begin
                if (tick_end)
                begin
                    smp_d  = switch_i;
                    deb_d  = BSMI_DEB_SECOND;
                    tick_d = '0;
                end
                else
                    tick_d = tick_q + 1'b1;
            end
            BSMI_DEB_SECOND:
            begin
                if (tick_end)
                begin
                    deb_d   = BSMI_DEB_IDLE;
                    press_d = (switch_i == smp_q) && !switch_i;
                end
                else
                    tick_d = tick_q + 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            deb_q   <= BSMI_DEB_IDLE;
            tick_q  <= '0;
            swp_q   <= 1'b1;
            smp_q   <= 1'b1;
            press_q <= 1'b0;
        end
        else
        begin
            deb_q   <= deb_d;
            tick_q  <= tick_d;
            swp_q   <= swp_d;
            smp_q   <= smp_d;
            press_q <= press_d;
        end
    end

    // ----------------------------------------------------------------
    // Step sequencer
    // ----------------------------------------------------------------
    logic [5:0]      step_q, step_d;
    bsmi_src_t       src_q, src_d;
    bsmi_mode_t      mode_q, mode_d;
    logic [4:0]      lamp_q, lamp_d;
    logic [WW-1:0]   wait_q, wait_d;
    bsmi_step_t      nxt;

    always_comb
    begin
        nxt    = step_cfg(step_q + 6'h01);
        seq_d  = seq_q;
        step_d = step_q;
        src_d  = src_q;
        mode_d = mode_q;
        lamp_d = lamp_q;
        wait_d = wait_q;
        unique case (seq_q)
            BSMI_SEQ_RUN:
            begin
                if (press_q)
                begin
                    if (step_q == `BSMI_LAST_STEP)
                    begin
                        seq_d  = BSMI_SEQ_PARK;
                        lamp_d = `BSMI_LAMPS_OFF;
                        mode_d = BSMI_MODE_HALT;
                    end
                    else
                    begin
                        step_d = step_q + 6'h01;
                        if (nxt.src != src_q)
                        begin
                            seq_d  = BSMI_SEQ_SWITCH;
                            src_d  = nxt.src;
                            wait_d = '0;
                        end
                        else
                        begin
                            mode_d = nxt.mode;
                            lamp_d = lamps(nxt);
                        end
                    end
                end
            end
            BSMI_SEQ_SWITCH:
            begin
                if (clk_ack_i)
                begin
                    seq_d  = BSMI_SEQ_RUN;
                    mode_d = step_cfg(step_q).mode;
                    lamp_d = lamps(step_cfg(step_q));
                end
                else if (wait_q == WW'(TIMEOUT_CYC - 1))
                begin
                    seq_d  = BSMI_SEQ_FAIL;
                    lamp_d = `BSMI_LAMPS_OFF;
                end
                else
                    wait_d = wait_q + 1'b1;
            end
            BSMI_SEQ_PARK:
                seq_d = BSMI_SEQ_PARK;
            BSMI_SEQ_FAIL:
                seq_d = BSMI_SEQ_FAIL;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            seq_q  <= BSMI_SEQ_RUN;
            step_q <= 6'h00;
            src_q  <= BSMI_SRC_HIGH;
            mode_q <= BSMI_MODE_NORMAL;
            lamp_q <= `BSMI_LAMPS_OFF;
            wait_q <= '0;
        end
        else
        begin
            seq_q  <= seq_d;
            step_q <= step_d;
            src_q  <= src_d;
            mode_q <= mode_d;
            lamp_q <= lamp_d;
            wait_q <= wait_d;
        end
    end

    assign clk_req_o = (seq_q == BSMI_SEQ_SWITCH);
    assign clk_src_o = src_q;
    assign op_mode_o = mode_q;
    assign lamp_o    = lamp_q;
    assign step_o    = step_q;
    assign parked_o  = (seq_q == BSMI_SEQ_PARK);
    assign fault_o   = (seq_q == BSMI_SEQ_FAIL);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_FALL_ONLY: assert property (deb_q == BSMI_DEB_IDLE && !fall |=> deb_q == BSMI_DEB_IDLE)
        else $error("Debounce started without a falling edge");
    AST_TICK_SAMPLE: assert property (deb_q == BSMI_DEB_FIRST && !tick_end |=> deb_q == BSMI_DEB_FIRST)
        else $error("Sample taken before the tick");
    AST_TWO_AGREE: assert property (press_q |-> $past(deb_q) == BSMI_DEB_SECOND && !$past(switch_i) && !$past(smp_q))
        else $error("Press accepted without two agreeing low samples");
    AST_ONE_STEP: assert property (press_q && seq_q == BSMI_SEQ_RUN && step_q != `BSMI_LAST_STEP |=> step_q == $past(step_q) + 6'h01)
        else $error("Press did not advance exactly one step");
    AST_SRC_LAMP: assert property (seq_q == BSMI_SEQ_RUN && step_q == 6'h16 |-> lamp_o[4:2] == `BSMI_LAMP_SRC_LOW)
        else $error("Source lamps wrong for low-speed step");
    AST_MODE_LAMP: assert property (seq_q == BSMI_SEQ_RUN && step_q == 6'h12 |-> lamp_o == 5'h11)
        else $error("Snooze step lamps wrong");
    AST_TABLE_LOW: assert property (seq_q == BSMI_SEQ_RUN && step_q == 6'h03 |-> src_q == BSMI_SRC_SUB && mode_q == BSMI_MODE_HALT && lamp_o == 5'h0E)
        else $error("Step 3 configuration wrong");
    AST_TABLE_HIGH: assert property (seq_q == BSMI_SEQ_RUN && step_q == 6'h1B |-> src_q == BSMI_SRC_MID && mode_q == BSMI_MODE_STOP && lamp_o == 5'h08)
        else $error("Step 27 configuration wrong");
    AST_PARK: assert property (press_q && seq_q == BSMI_SEQ_RUN && step_q == `BSMI_LAST_STEP |=> parked_o && lamp_o == 5'h00)
        else $error("Final press did not park with lamps off");
    AST_PARK_STAY: assert property (parked_o |=> parked_o && lamp_o == 5'h00 && deb_q == BSMI_DEB_IDLE)
        else $error("Parked state left without reset");
    AST_TIMEOUT: assert property (clk_req_o && !clk_ack_i && wait_q == WW'(TIMEOUT_CYC - 1) |=> fault_o && lamp_o == 5'h00 ##1 fault_o)
        else $error("Clock switch timeout not handled");
    AST_MISMATCH: assert property (deb_q == BSMI_DEB_SECOND && tick_end && switch_i != smp_q |=> deb_q == BSMI_DEB_IDLE && !press_q)
        else $error("Sample mismatch did not drop the candidate");

    CV_PRESS: cover property (press_q && seq_q == BSMI_SEQ_RUN);
    CV_SWITCH: cover property (clk_req_o ##1 clk_ack_i);
    CV_PARK: cover property ($rose(parked_o));
    CV_FAULT: cover property ($rose(fault_o));

endmodule // bsmi_top

// ### bench/bsmi_partner.sv
// ----------------------------------------------------------------
// Push-button and clock source model
// ----------------------------------------------------------------
module bsmi_partner (
    input  wire logic       clk_i,
    input  wire logic       clk_req_i,
    input  wire logic [3:0] ack_delay_i,
    input  wire logic       ack_en_i,
    input  wire logic       ack_stray_i,
    output logic            switch_o,
    output logic            clk_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_q;

    initial
    begin
        switch_o  = 1'b1;
        clk_ack_o = 1'b0;
        wait_q    = 4'h0;
    end

    // Oscillator settles after a programmable delay, or never when disabled
    always @(negedge clk_i)
    begin
        if (!clk_req_i)
            wait_q <= 4'h0;
        else if (wait_q != 4'hF)
            wait_q <= wait_q + 4'h1;
        clk_ack_o <= ack_stray_i | (clk_req_i & ack_en_i & (wait_q >= ack_delay_i));
    end

    // Button held low for low_cyc cycles; optional contact bounce after the fall
    task automatic press(input logic bnc, input int low_cyc);
        @(negedge clk_i);
        switch_o = 1'b0;
        if (bnc)
        begin
            @(negedge clk_i);
            switch_o = 1'b1;
            @(negedge clk_i);
            switch_o = 1'b0;
        end
        repeat (low_cyc) @(negedge clk_i);
        switch_o = 1'b1;
    endtask
endmodule // bsmi_partner

// ### bench/tb_top.sv
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module tb_top;
    import bsmi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int    TICK = 4;
    localparam string SRC_S = {"HSSSHXSXXXXXHHHHHHH", "MXLXMMMMMMMSMLMHLLLH"};
    localparam string MODE_S = {"NNHNNNNNHNPNNHNPNZN", "NNNNNHNPNZNNNNNNNHNN"};

    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       switch_w;
    logic       clk_ack_w;
    logic       clk_req_o;
    bsmi_src_t  clk_src_o;
    bsmi_mode_t op_mode_o;
    logic [4:0] lamp_o;
    logic [5:0] step_o;
    logic       parked_o;
    logic       fault_o;
    logic [3:0] ack_delay = 4'h0;
    logic       ack_en = 1'b1;
    logic       ack_stray = 1'b0;
    int         mismatches = 0;
    int         total_checks = 0;

    always #25 clk = ~clk;

    bsmi_top #(.TICK_CYC(TICK), .TIMEOUT_CYC(8)) bsmi_top_inst (
        .clk_i(clk), .resetn_i(resetn), .switch_i(switch_w), .clk_ack_i(clk_ack_w),
        .clk_req_o(clk_req_o), .clk_src_o(clk_src_o), .op_mode_o(op_mode_o),
        .lamp_o(lamp_o), .step_o(step_o), .parked_o(parked_o), .fault_o(fault_o)
    );

    bsmi_partner bsmi_partner_inst (
        .clk_i(clk), .clk_req_i(clk_req_o), .ack_delay_i(ack_delay), .ack_en_i(ack_en),
        .ack_stray_i(ack_stray), .switch_o(switch_w), .clk_ack_o(clk_ack_w)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [4:0] exp_lamp(input int n);
        logic [2:0] s;
        logic [1:0] m;
        case (SRC_S[n-1])
            "H": s = 3'h4;
            "M": s = 3'h2;
            "L": s = 3'h6;
            "X": s = 3'h5;
            default: s = 3'h3;
        endcase
        case (MODE_S[n-1])
            "N": m = 2'h3;
            "H": m = 2'h2;
            "P": m = 2'h0;
            default: m = 2'h1;
        endcase
        return {s, m};
    endfunction

    function automatic bsmi_step_t exp_step(input int n);
        bsmi_step_t r;
        case (SRC_S[n-1])
            "H": r.src = BSMI_SRC_HIGH;
            "M": r.src = BSMI_SRC_MID;
            "L": r.src = BSMI_SRC_LOW;
            "X": r.src = BSMI_SRC_EXT;
            default: r.src = BSMI_SRC_SUB;
        endcase
        case (MODE_S[n-1])
            "N": r.mode = BSMI_MODE_NORMAL;
            "H": r.mode = BSMI_MODE_HALT;
            "P": r.mode = BSMI_MODE_STOP;
            default: r.mode = BSMI_MODE_SNOOZE;
        endcase
        return r;
    endfunction

    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (clk_req_o !== 1'b0 && k < 30)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 30)
        begin
            mismatches++;
            results();
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_state();
        check({parked_o, fault_o, clk_req_o, step_o}, 8'h00);
        check({clk_src_o, op_mode_o, lamp_o[2:0]}, 8'h00);
        ack_stray = 1'b1;
        repeat (4) @(negedge clk);
        ack_stray = 1'b0;
        check({lamp_o, clk_req_o, fault_o}, 7'h00);
    endtask

    task automatic t_refused_press(input int low_cyc);
        bsmi_partner_inst.press(1'b0, low_cyc);
        repeat (3 * TICK) @(negedge clk);
        check({step_o, lamp_o[1:0]}, 8'h00);
    endtask

    task automatic step_once(input int n, input logic bnc);
        fork
            bsmi_partner_inst.press(bnc, 2 * TICK + 4);
            begin
                repeat (2 * TICK) @(negedge clk);
                check(step_o, 16'(n - 1));
            end
        join
        wait_idle();
        check(step_o, 16'(n));
        check(lamp_o, exp_lamp(n));
        check({clk_src_o, op_mode_o}, exp_step(n));
    endtask

    task automatic t_walk();
        for (int n = 1; n <= 39; n++)
        begin
            ack_delay = (n % 3 == 0) ? 4'h4 : 4'h0;
            step_once(n, n[0]);
        end
    endtask

    task automatic t_final();
        for (int i = 0; i < 2; i++)
        begin
            bsmi_partner_inst.press(1'b0, 2 * TICK + 4);
            repeat (TICK) @(negedge clk);
            check({parked_o, fault_o, step_o}, 8'hA7);
            check({lamp_o, op_mode_o}, {5'h00, BSMI_MODE_HALT});
        end
    endtask

    task automatic t_timeout();
        int k;
        step_once(1, 1'b0);
        ack_en = 1'b0;
        bsmi_partner_inst.press(1'b0, 2 * TICK + 4);
        k = 0;
        while (fault_o !== 1'b1 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        check({fault_o, clk_req_o, lamp_o}, 7'h40);
        if (k == 40)
            results();
        bsmi_partner_inst.press(1'b0, 2 * TICK + 4);
        repeat (TICK) @(negedge clk);
        check({fault_o, parked_o, step_o}, 8'h82);
        check(lamp_o, 5'h00);
    endtask

    initial
    begin
        do_reset();
        t_reset_state();
        t_refused_press(1);
        t_refused_press(TICK + 3);
        t_walk();
        t_final();
        do_reset();
        t_timeout();
        results();
    end
endmodule // tb_top
